// ==== bmc_consts.svh ====
// Constants for the block magnitude compare sequencer
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH

// -----------------------------------------------------------------
// Operation encodings
// -----------------------------------------------------------------
`define BMC_OP_MEM_NOT_BELOW 2'h0
`define BMC_OP_BLK_NOT_BELOW 2'h1
`define BMC_OP_MEM_BORROW 2'h2
`define BMC_OP_BLK_BORROW 2'h3

// -----------------------------------------------------------------
// Flag bit positions in the packed flag word
// -----------------------------------------------------------------
`define BMC_FLAG_SIGN 4
`define BMC_FLAG_ZERO 3
`define BMC_FLAG_NIBBLE 2
`define BMC_FLAG_OVF 1
`define BMC_FLAG_BORROW 0

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define BMC_PTR_RESET 16'h0000
`define BMC_CNT_RESET 8'h00
`define BMC_FLAGS_RESET 5'h00

`endif

// ==== bmc_pkg.sv ====
// Types shared by the block magnitude compare sequencer
package bmc_pkg;

  // -----------------------------------------------------------------
  // Operation and state types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    BMC_MEM_NOT_BELOW = 2'h0,
    BMC_BLK_NOT_BELOW = 2'h1,
    BMC_MEM_BORROW = 2'h2,
    BMC_BLK_BORROW = 2'h3
  } bmc_op_t;

  typedef enum logic [2:0] {
    BMC_IDLE = 3'h0,
    BMC_RD_FIRST = 3'h1,
    BMC_RD_SECOND = 3'h2,
    BMC_EXEC = 3'h3,
    BMC_SUSPEND = 3'h4
  } bmc_state_t;

  // -----------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic sign;
    logic zero;
    logic nibble_borrow_flag;
    logic overflow;
    logic borrow_flag;
  } bmc_flags_t;

  typedef struct packed {
    bmc_op_t op;
    logic descending;
    logic [15:0] first_pointer;
    logic [15:0] second_pointer;
    logic [7:0] count;
    logic [7:0] acc;
  } bmc_start_t;

  typedef struct packed {
    logic [15:0] first_pointer;
    logic [15:0] second_pointer;
    logic [7:0] count;
  } bmc_regs_t;

endpackage

// ==== bmc_compare.sv ====
// Repeated byte magnitude compare sequencer and flag datapath
//
// Operation
// - mem minus acc, stop at zero count or no borrow
// - first minus second, stop at zero or no borrow
// - mem minus acc, stop at zero or borrow
// - first minus second, stop at zero or borrow
// - pointers step up or down per step
// - accumulator and memory never written
// - suspend between steps for interrupt/service
// - resume from saved pointers and counter
// - continue automatically after macro service
// - flags come from final subtraction
// - sign flag equals result bit seven
// - zero flag set on zero result
// - nibble borrow from bit four into three
// - overflow is borrow six xor seven
// - borrow flag is borrow out of bit seven
// - second byte above first ends a first-minus-second stop-on-borrow run
//
`timescale 1ns/1ps
`default_nettype none
`include "bmc_consts.svh"

module bmc_compare (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Instruction start and resume
  input wire logic start_i,
  input wire logic resume_i,
  input wire bmc_pkg::bmc_start_t start_cfg_i,
  input wire bmc_pkg::bmc_regs_t resume_regs_i,
  // Suspension requests
  input wire logic irq_req_i,
  input wire logic macro_req_i,
  input wire logic macro_done_i,
  // Memory read port
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_data_i,
  // Status and architectural results
  output logic busy_o,
  output logic done_o,
  output logic irq_ack_o,
  output logic macro_ack_o,
  output logic suspended_o,
  output bmc_pkg::bmc_regs_t regs_o,
  output bmc_pkg::bmc_flags_t flags_o
);

  // -----------------------------------------------------------------
  // Subtraction helper
  // -----------------------------------------------------------------
  // Returns {sign, zero, nibble, overflow, borrow} for a minus b
  function automatic logic [4:0] sub_flags(input logic [7:0] a,
                                           input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] low7;
    logic b6;
    logic b7;
    begin
      full = {1'b0, a} - {1'b0, b};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      low7 = {1'b0, a[6:0]} - {1'b0, b[6:0]};
      b6 = low7[7];
      b7 = full[8];
      sub_flags = {full[7], (full[7:0] == 8'h00), low[4], b6 ^ b7, b7};
    end
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  bmc_pkg::bmc_state_t state_reg, state_next;
  bmc_pkg::bmc_op_t op_reg;
  logic desc_reg;
  logic by_macro_reg;
  logic [7:0] acc_reg;
  logic [7:0] first_byte_reg;
  logic [7:0] second_byte_reg;
  logic [15:0] first_ptr_reg;
  logic [15:0] second_ptr_reg;
  logic [7:0] cnt_reg;
  logic [4:0] flags_reg;
  logic mem_rd_reg;
  logic [15:0] mem_addr_reg;
  logic done_reg;
  logic irq_ack_reg;
  logic macro_ack_reg;

  // -----------------------------------------------------------------
  // Step decode
  // -----------------------------------------------------------------
  // Accumulator operand only read; never written back
  wire two_ptr = (op_reg == bmc_pkg::BMC_BLK_NOT_BELOW) ||
                 (op_reg == bmc_pkg::BMC_BLK_BORROW);
  wire stop_on_borrow = (op_reg == bmc_pkg::BMC_MEM_BORROW) ||
                        (op_reg == bmc_pkg::BMC_BLK_BORROW);
  wire [7:0] subtrahend = two_ptr ? second_byte_reg : acc_reg;
  wire [4:0] step_flags = sub_flags(first_byte_reg, subtrahend);
  wire step_borrow = step_flags[`BMC_FLAG_BORROW];
  // Decrement first, then test: zero start gives 256 steps
  wire [7:0] cnt_dec = cnt_reg - 8'h01;
  wire step_end = (cnt_dec == 8'h00) ||
                  (stop_on_borrow ? step_borrow : !step_borrow);
  wire [15:0] ptr_step = desc_reg ? 16'hFFFF : 16'h0001;
  wire susp_req = irq_req_i || macro_req_i;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  // Requests only honoured at a step boundary, never mid-read
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bmc_pkg::BMC_IDLE: begin
        if (start_i || resume_i) begin
          state_next = bmc_pkg::BMC_RD_FIRST;
        end
      end
      bmc_pkg::BMC_RD_FIRST: begin
        if (mem_ack_i) begin
          state_next = two_ptr ? bmc_pkg::BMC_RD_SECOND
                               : bmc_pkg::BMC_EXEC;
        end
      end
      bmc_pkg::BMC_RD_SECOND: begin
        if (mem_ack_i) begin
          state_next = bmc_pkg::BMC_EXEC;
        end
      end
      bmc_pkg::BMC_EXEC: begin
        if (step_end) begin
          state_next = bmc_pkg::BMC_IDLE;
        end else if (macro_req_i) begin
          state_next = bmc_pkg::BMC_SUSPEND;
        end else if (irq_req_i) begin
          state_next = bmc_pkg::BMC_IDLE;
        end else begin
          state_next = bmc_pkg::BMC_RD_FIRST;
        end
      end
      bmc_pkg::BMC_SUSPEND: begin
        if (macro_done_i) begin
          state_next = bmc_pkg::BMC_RD_FIRST;
        end
      end
      default: begin
        state_next = bmc_pkg::BMC_IDLE;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Sequencer and datapath registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= bmc_pkg::BMC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Operand capture and pointer/counter stepping
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      op_reg <= bmc_pkg::BMC_MEM_NOT_BELOW;
      desc_reg <= 1'b0;
      acc_reg <= 8'h00;
      first_ptr_reg <= `BMC_PTR_RESET;
      second_ptr_reg <= `BMC_PTR_RESET;
      cnt_reg <= `BMC_CNT_RESET;
      first_byte_reg <= 8'h00;
      second_byte_reg <= 8'h00;
    end else begin
      if (state_reg == bmc_pkg::BMC_IDLE && start_i) begin
        op_reg <= start_cfg_i.op;
        desc_reg <= start_cfg_i.descending;
        acc_reg <= start_cfg_i.acc;
        first_ptr_reg <= start_cfg_i.first_pointer;
        second_ptr_reg <= start_cfg_i.second_pointer;
        cnt_reg <= start_cfg_i.count;
      end else if (state_reg == bmc_pkg::BMC_IDLE && resume_i) begin
        // Op, direction and acc kept from the suspended run
        first_ptr_reg <= resume_regs_i.first_pointer;
        second_ptr_reg <= resume_regs_i.second_pointer;
        cnt_reg <= resume_regs_i.count;
      end
      if (state_reg == bmc_pkg::BMC_RD_FIRST && mem_ack_i) begin
        first_byte_reg <= mem_data_i;
      end
      if (state_reg == bmc_pkg::BMC_RD_SECOND && mem_ack_i) begin
        second_byte_reg <= mem_data_i;
      end
      if (state_reg == bmc_pkg::BMC_EXEC) begin
        first_ptr_reg <= first_ptr_reg + ptr_step;
        if (two_ptr) begin
          second_ptr_reg <= second_ptr_reg + ptr_step;
        end
        cnt_reg <= cnt_dec;
      end
    end
  end

  // Flags track each step, so the final step's values remain
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags_reg <= `BMC_FLAGS_RESET;
    end else if (state_reg == bmc_pkg::BMC_EXEC) begin
      flags_reg <= step_flags;
    end
  end

  // -----------------------------------------------------------------
  // Memory port and handshake outputs
  // -----------------------------------------------------------------
  wire rd_first_next = (state_next == bmc_pkg::BMC_RD_FIRST);
  wire rd_second_next = (state_next == bmc_pkg::BMC_RD_SECOND);
  wire [15:0] first_addr_next =
    (state_reg == bmc_pkg::BMC_IDLE && start_i) ?
      start_cfg_i.first_pointer :
    (state_reg == bmc_pkg::BMC_IDLE) ? resume_regs_i.first_pointer :
    (state_reg == bmc_pkg::BMC_EXEC) ? first_ptr_reg + ptr_step :
    first_ptr_reg;
  wire [15:0] second_addr_next = second_ptr_reg;

  // Read request held until acknowledged
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mem_rd_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
    end else begin
      mem_rd_reg <= (rd_first_next || rd_second_next) &&
                    !(state_reg != state_next ? 1'b0 : mem_ack_i);
      if (rd_first_next) begin
        mem_addr_reg <= first_addr_next;
      end else if (rd_second_next) begin
        mem_addr_reg <= second_addr_next;
      end
    end
  end

  // Completion and acknowledge pulses
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
      irq_ack_reg <= 1'b0;
      macro_ack_reg <= 1'b0;
      by_macro_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == bmc_pkg::BMC_EXEC) && step_end;
      irq_ack_reg <= (state_reg == bmc_pkg::BMC_EXEC) && !step_end &&
                     !macro_req_i && irq_req_i;
      macro_ack_reg <= (state_reg == bmc_pkg::BMC_EXEC) && !step_end &&
                       macro_req_i;
      if (state_next == bmc_pkg::BMC_SUSPEND) begin
        by_macro_reg <= 1'b1;
      end else begin
        by_macro_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Output drive
  // -----------------------------------------------------------------
  assign mem_rd_o = mem_rd_reg;
  assign mem_addr_o = mem_addr_reg;
  assign busy_o = (state_reg != bmc_pkg::BMC_IDLE) && !susp_idle();
  assign done_o = done_reg;
  assign irq_ack_o = irq_ack_reg;
  assign macro_ack_o = macro_ack_reg;
  assign suspended_o = by_macro_reg;
  assign regs_o = {first_ptr_reg, second_ptr_reg, cnt_reg};
  assign flags_o = flags_reg;

  // Busy excludes the macro service wait
  function automatic logic susp_idle();
    susp_idle = (state_reg == bmc_pkg::BMC_SUSPEND);
  endfunction

endmodule
`default_nettype wire

// ==== bmc_compare_props.sv ====
// Checker for the block magnitude compare sequencer
`timescale 1ns/1ps
`default_nettype none
module bmc_compare_props (
  // Clock, reset and control
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire bmc_pkg::bmc_start_t start_cfg_i,
  input wire logic macro_done_i,
  // Memory port and status
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic irq_ack_o,
  input wire logic macro_ack_o,
  input wire logic suspended_o,
  input wire bmc_pkg::bmc_regs_t regs_o,
  input wire bmc_pkg::bmc_flags_t flags_o
);
  // ---------------------------------------------------------------
  // Run setup seen at start; resume keeps op and direction
  // ---------------------------------------------------------------
  logic op_hi_reg;
  logic desc_reg;
  always_ff @(posedge clock_i) begin
    if (start_i && !busy_o && !suspended_o) begin
      op_hi_reg <= start_cfg_i.op[1];
      desc_reg <= start_cfg_i.descending;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_stall; mem_rd_o && !mem_ack_i; endsequence
  sequence s_take; start_i && !busy_o && !suspended_o; endsequence
  sequence s_release; suspended_o && macro_done_i; endsequence
  sequence s_step; $past(busy_o) && $changed(regs_o.count); endsequence
  property p_rd_hold; s_stall |=> mem_rd_o && $stable(mem_addr_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read request dropped or moved before ack");
  property p_start_rd;
    s_take |=> mem_rd_o && mem_addr_o == $past(start_cfg_i.first_pointer);
  endproperty
  a_start_rd: assert property (p_start_rd)
    else $error("first read not at first pointer");
  property p_stop;
    done_o |-> regs_o.count == 8'h00 || flags_o.borrow_flag == op_hi_reg;
  endproperty
  a_stop: assert property (p_stop)
    else $error("run ended without its stop condition");
  property p_zero; flags_o.zero |-> flags_o[4] == 1'b0 && flags_o[2:0] == 3'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero result with a borrow or sign flag");
  property p_count; s_step |-> regs_o.count == $past(regs_o.count) - 8'h01;
  endproperty
  a_count: assert property (p_count)
    else $error("counter not stepped by one");
  property p_ptr; s_step |-> regs_o.first_pointer ==
    $past(regs_o.first_pointer) + (desc_reg ? 16'hFFFF : 16'h0001);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer not stepped by one");
  property p_macro; macro_ack_o |-> suspended_o && !busy_o && !mem_rd_o;
  endproperty
  a_macro: assert property (p_macro)
    else $error("macro service not suspending the run");
  property p_macro_go; s_release |-> ##[1:3] mem_rd_o; endproperty
  a_macro_go: assert property (p_macro_go)
    else $error("run not continued after macro service");
  property p_irq; irq_ack_o |-> !busy_o && !suspended_o && !mem_rd_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt accepted while still running");
endmodule
bind bmc_compare bmc_compare_props u_bmc_compare_props (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
  .start_cfg_i(start_cfg_i), .macro_done_i(macro_done_i),
  .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
  .busy_o(busy_o), .done_o(done_o), .irq_ack_o(irq_ack_o),
  .macro_ack_o(macro_ack_o), .suspended_o(suspended_o),
  .regs_o(regs_o), .flags_o(flags_o));
`default_nettype wire

// ==== bmc_mem_model.sv ====
// Memory read port model facing the compare sequencer
`timescale 1ns/1ps
`default_nettype none
module bmc_mem_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Read port
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic slow_i,
  output logic mem_ack_o,
  output logic [7:0] mem_data_o
);
  // Byte store; no write path, so compared data cannot change
  logic [7:0] mem [0:255];
  logic [2:0] wait_cnt;
  // Answer at once or after three waits; data scrambled between acks
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      mem_data_o <= 8'hA5;
      wait_cnt <= 3'h0;
    end else if (mem_rd_i && !mem_ack_o &&
                 wait_cnt >= (slow_i ? 3'h3 : 3'h0)) begin
      mem_ack_o <= 1'b1;
      mem_data_o <= mem[mem_addr_i[7:0]];
      wait_cnt <= 3'h0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
      if (mem_rd_i && !mem_ack_o) wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== test_block_magnitude_compare.sv ====
// Self-checking bench for the block magnitude compare sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_block_magnitude_compare;
  logic clock_i, sys_rst_i, start_i, resume_i, irq_req_i, macro_req_i;
  logic macro_done_i, mem_rd_o, mem_ack_i, busy_o, done_o, irq_ack_o;
  logic macro_ack_o, suspended_o, slow;
  logic [15:0] mem_addr_o;
  logic [7:0] mem_data_i;
  logic [2:0] ev;
  bmc_pkg::bmc_start_t cfg;
  bmc_pkg::bmc_regs_t resume_regs_i, regs_o;
  bmc_pkg::bmc_flags_t flags_o;
  logic [7:0] img [0:255];
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  assign ev = {irq_ack_o, macro_ack_o, done_o};
  bmc_compare u_bmc_compare (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .resume_i(resume_i), .start_cfg_i(cfg),
    .resume_regs_i(resume_regs_i), .irq_req_i(irq_req_i),
    .macro_req_i(macro_req_i), .macro_done_i(macro_done_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .mem_data_i(mem_data_i), .busy_o(busy_o), .done_o(done_o),
    .irq_ack_o(irq_ack_o), .macro_ack_o(macro_ack_o),
    .suspended_o(suspended_o), .regs_o(regs_o), .flags_o(flags_o));
  bmc_mem_model u_bmc_mem_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .slow_i(slow),
    .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
  // 50 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Hang guard, far above the few thousand cycles the runs need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Shared drivers and reference
  // -----------------------------------------------------------------
  task automatic launch(input bmc_pkg::bmc_start_t c, input logic res);
    @(posedge clock_i);
    cfg <= c;
    start_i <= !res;
    resume_i <= res;
    @(posedge clock_i);
    start_i <= 1'b0;
    resume_i <= 1'b0;
  endtask
  // Bounded wait for done (0), macro ack (1) or interrupt ack (2)
  task automatic await(input int k);
    int n;
    n = 0;
    while (ev[k] !== 1'b1 && n < 5000) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 5000) begin
      err_count++;
      $display("MISMATCH handshake %0d exp 1 got 0", k);
    end
  endtask
  // Walk the steps from the start setup and compare the end state
  task automatic judge(input bmc_pkg::bmc_start_t c);
    logic [7:0] a, b, r;
    logic cy;
    bmc_pkg::bmc_flags_t f;
    do begin
      a = img[c.first_pointer[7:0]];
      b = c.op[0] ? img[c.second_pointer[7:0]] : c.acc;
      r = a - b;
      cy = a < b;
      f = '{r[7], r == 8'h00, a[3:0] < b[3:0], (a[6:0] < b[6:0]) ^ cy, cy};
      c.first_pointer += c.descending ? 16'hFFFF : 16'h0001;
      if (c.op[0]) c.second_pointer += c.descending ? 16'hFFFF : 16'h0001;
      c.count -= 8'h01;
    end while (c.count != 8'h00 && cy != c.op[1]);
    `CHK("first_pointer", c.first_pointer, regs_o.first_pointer)
    `CHK("second_pointer", c.second_pointer, regs_o.second_pointer)
    `CHK("count", c.count, regs_o.count)
    `CHK("flags", f, flags_o)
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  // Every op both ways, back to back; end state shows each stop rule
  task automatic t_all_ops();
    bmc_pkg::bmc_start_t c;
    for (int i = 0; i < 8; i++) begin
      c = '{bmc_pkg::bmc_op_t'(i[1:0]), i[2], 16'h0040, 16'h0080,
            8'h10, 8'h90};
      launch(c, 1'b0);
      await(0);
      judge(c);
    end
  endtask
  // Count zero gives 256 steps; slow memory stalls each read
  task automatic t_count_zero();
    bmc_pkg::bmc_start_t c;
    c = '{bmc_pkg::BMC_MEM_BORROW, 1'b0, 16'h0100, 16'h0000, 8'h00, 8'h00};
    slow <= 1'b1;
    launch(c, 1'b0);
    await(0);
    judge(c);
    slow <= 1'b0;
  endtask
  // Interrupt mid-run, then resume from unaltered registers
  task automatic t_irq();
    bmc_pkg::bmc_start_t c;
    c = '{bmc_pkg::BMC_MEM_BORROW, 1'b1, 16'h0300, 16'h0000, 8'h00, 8'h00};
    launch(c, 1'b0);
    repeat (20) @(posedge clock_i);
    irq_req_i <= 1'b1;
    await(2);
    `CHK("busy at irq ack", 1'b0, busy_o)
    @(posedge clock_i);
    irq_req_i <= 1'b0;
    resume_regs_i <= regs_o;
    launch(c, 1'b1);
    await(0);
    judge(c);
  endtask
  // Macro service wins over a coincident interrupt, then continues
  task automatic t_macro();
    bmc_pkg::bmc_start_t c;
    c = '{bmc_pkg::BMC_MEM_BORROW, 1'b0, 16'h0010, 16'h0000, 8'h00, 8'h00};
    launch(c, 1'b0);
    repeat (30) @(posedge clock_i);
    macro_req_i <= 1'b1;
    irq_req_i <= 1'b1;
    await(1);
    @(posedge clock_i);
    macro_req_i <= 1'b0;
    irq_req_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    `CHK("suspended", 1'b1, suspended_o)
    macro_done_i <= 1'b1;
    @(posedge clock_i);
    macro_done_i <= 1'b0;
    await(0);
    judge(c);
  endtask
  // Reset, memory image, then the scenarios
  initial begin
    sys_rst_i = 1'b1;
    start_i = 1'b0;
    resume_i = 1'b0;
    irq_req_i = 1'b0;
    macro_req_i = 1'b0;
    macro_done_i = 1'b0;
    slow = 1'b0;
    cfg = '0;
    resume_regs_i = '0;
    for (int i = 0; i < 256; i++) begin
      img[i] = 8'(i * 157 + 3);
      u_bmc_mem_model.mem[i] = img[i];
    end
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_all_ops();
    t_count_zero();
    t_irq();
    t_macro();
    results();
  end
endmodule
`default_nettype wire
